/* File: src/vliw_packet_dispatch_crosspath.sv */
// fetch group splitter, packet issue, two register files and cross buses
// assumes fetch memory and functional units run on sys_clk
`include "vliw_dispatch_params.svh"
module vliw_packet_dispatch_crosspath (
    input  wire logic                           sys_clk,
    input  wire logic                           rst,
    output logic                                fetch_req,
    output logic [31:0]                         fetch_addr,
    input  wire logic                           fetch_valid,
    input  wire logic [`GROUP_WORDS-1:0][31:0]  fetch_data,
    output logic [`NUM_UNITS-1:0]               issue_valid,
    output vliw_dispatch_pkg::issue_slot_t [`NUM_UNITS-1:0] issue_slot,
    output logic                                stall,
    input  wire vliw_dispatch_pkg::wb_port_t [`NUM_UNITS-1:0] wb_port
);
    // ----------------------------------------------------------------
    // decode helpers
    // ----------------------------------------------------------------
    function automatic logic [2:0] unit_of(input logic [31:0] ins);
        return ins[`UNIT_HI:`UNIT_LO];
    endfunction : unit_of

    function automatic logic [4:0] src_of(input logic [31:0] ins);
        return ins[`SRC_HI:`SRC_LO];
    endfunction : src_of

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    vliw_dispatch_pkg::disp_state_t           state, next_state;
    logic [`GROUP_WORDS-1:0][31:0]            grp, next_grp;
    logic [2:0]                               ptr, next_ptr;
    logic [`NUM_UNITS-1:0]                    part_vld, next_part_vld;
    logic [`NUM_UNITS-1:0][31:0]              part_ins, next_part_ins;
    logic                                     stalled, next_stalled;
    logic                                     next_fetch_req;
    logic [31:0]                              next_fetch_addr;
    logic [`NUM_UNITS-1:0]                    next_issue_valid;
    vliw_dispatch_pkg::issue_slot_t [`NUM_UNITS-1:0] next_issue_slot;
    logic                                     next_stall;
    logic [1:0][`NUM_REGS-1:0][31:0]          rf, next_rf;
    logic [1:0][`NUM_REGS-1:0]                wrote, next_wrote;

    // combinational working values
    logic [`GROUP_WORDS-1:0]                  in_pkt;
    logic                                     live, found;
    logic [2:0]                               last;
    logic [`NUM_UNITS-1:0]                    pv;
    logic [`NUM_UNITS-1:0][31:0]              pi;
    logic [1:0]                               xuse;
    logic [1:0][4:0]                          xreg;
    logic [1:0][31:0]                         xbus;
    logic                                     hazard;

    // ----------------------------------------------------------------
    // dispatch next-state logic
    // ----------------------------------------------------------------
    always_comb begin
        next_state       = state;
        next_grp         = grp;
        next_ptr         = ptr;
        next_part_vld    = part_vld;
        next_part_ins    = part_ins;
        next_stalled     = stalled;
        next_fetch_req   = 1'b0;
        next_fetch_addr  = fetch_addr;
        next_issue_valid = '0; // idle units get nothing
        next_issue_slot  = issue_slot;
        next_stall       = 1'b0;
        // walk the chain from ptr until an lsb of zero
        in_pkt = '0;
        live   = 1'b1;
        found  = 1'b0;
        last   = 3'h7;
        for (int j = 0; j < `GROUP_WORDS; j++) begin
            if (3'(j) >= ptr && live) begin
                in_pkt[j] = 1'b1;
                if (!grp[j][`CHAIN_BIT]) begin
                    live  = 1'b0;
                    found = 1'b1;
                    last  = 3'(j);
                end
            end
        end
        // merge any carried-over part with this group's share
        pv = part_vld;
        pi = part_ins;
        for (int j = 0; j < `GROUP_WORDS; j++) begin
            if (in_pkt[j]) begin
                pv[unit_of(grp[j])] = 1'b1; // one slot per unit
                pi[unit_of(grp[j])] = grp[j];
            end
        end
        // one cross bus per side, lowest using unit names the register
        for (int s = 0; s < 2; s++) begin
            xuse[s] = 1'b0;
            xreg[s] = 5'h00;
            for (int k = 3; k >= 0; k--) begin
                if (pv[s*4+k] && pi[s*4+k][`CROSS_BIT]) begin
                    xuse[s] = 1'b1;
                    xreg[s] = src_of(pi[s*4+k]);
                end
            end
            xbus[s] = rf[1-s][xreg[s]];
        end
        hazard = (xuse[0] && wrote[1][xreg[0]]) || (xuse[1] && wrote[0][xreg[1]]);
        unique case (state)
            vliw_dispatch_pkg::ST_REQ: begin
                next_fetch_req = 1'b1; // fixed 256-bit group
                next_state     = vliw_dispatch_pkg::ST_WAIT;
            end
            vliw_dispatch_pkg::ST_WAIT: begin
                if (fetch_valid) begin
                    next_grp   = fetch_data;
                    next_ptr   = 3'h0;
                    next_state = vliw_dispatch_pkg::ST_RUN;
                end
            end
            vliw_dispatch_pkg::ST_RUN: begin
                if (!found) begin
                    // chain runs past the group end: carry it over
                    next_part_vld   = pv;
                    next_part_ins   = pi;
                    next_fetch_addr = fetch_addr + `GROUP_BYTES;
                    next_state      = vliw_dispatch_pkg::ST_REQ;
                end else if (hazard && !stalled) begin
                    next_stalled = 1'b1; // one delay clock
                    next_stall   = 1'b1;
                end else begin
                    // whole packet goes out in this one cycle
                    next_stalled     = 1'b0;
                    next_issue_valid = pv;
                    next_part_vld    = '0;
                    for (int u = 0; u < `NUM_UNITS; u++) begin
                        next_issue_slot[u].instr = pi[u];
                        // packed lanes pass through untouched
                        next_issue_slot[u].mode =
                            vliw_dispatch_pkg::op_mode_t'(pi[u][`MODE_HI:`MODE_LO]);
                        next_issue_slot[u].opnd = pi[u][`CROSS_BIT] ? xbus[u/4]
                                                : rf[u/4][src_of(pi[u])];
                        next_issue_slot[u].opnd_hi = rf[u/4][src_of(pi[u]) | 5'h01];
                    end
                    if (last == 3'h7) begin
                        // group exhausted, only now fetch the next
                        next_fetch_addr = fetch_addr + `GROUP_BYTES;
                        next_state      = vliw_dispatch_pkg::ST_REQ;
                    end else begin
                        next_ptr = last + 3'h1;
                    end
                end
            end
        endcase
    end

    // dispatch registers; reset drops the partial packet
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            state       <= vliw_dispatch_pkg::ST_REQ;
            grp         <= '0;
            ptr         <= 3'h0;
            part_vld    <= '0;
            part_ins    <= '0;
            stalled     <= 1'b0;
            fetch_req   <= 1'b0;
            fetch_addr  <= `RESET_PC;
            issue_valid <= '0;
            issue_slot  <= '0;
            stall       <= 1'b0;
        end else begin
            state       <= next_state;
            grp         <= next_grp;
            ptr         <= next_ptr;
            part_vld    <= next_part_vld;
            part_ins    <= next_part_ins;
            stalled     <= next_stalled;
            fetch_req   <= next_fetch_req;
            fetch_addr  <= next_fetch_addr;
            issue_valid <= next_issue_valid;
            issue_slot  <= next_issue_slot;
            stall       <= next_stall;
        end
    end

    // ----------------------------------------------------------------
    // register files: units 0-3 write side 0, units 4-7 side 1
    // ----------------------------------------------------------------
    always_comb begin
        next_rf    = rf;
        next_wrote = '0;
        for (int u = 0; u < `NUM_UNITS; u++) begin
            if (wb_port[u].en) begin
                next_rf[u/4][wb_port[u].idx]    = wb_port[u].data;
                next_wrote[u/4][wb_port[u].idx] = 1'b1;
            end
        end
    end

    // register storage and last-cycle write marks for the cross check
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            rf    <= '0;
            wrote <= '0; // stall logic starts clear
        end else begin
            rf    <= next_rf;
            wrote <= next_wrote;
        end
    end
endmodule : vliw_packet_dispatch_crosspath

/* File: shared/vliw_dispatch_params.svh */
// constants for the vliw packet dispatcher and its two register files
// assumes one core clock and that the fetch path and units share it
`ifndef VLIW_DISPATCH_PARAMS_SVH
`define VLIW_DISPATCH_PARAMS_SVH
`define INSTR_W     32
`define GROUP_WORDS 8
`define GROUP_BYTES 32'h0000_0020
`define NUM_UNITS   8
`define NUM_REGS    32
`define CHAIN_BIT   0
`define UNIT_HI     3
`define UNIT_LO     1
`define SRC_HI      8
`define SRC_LO      4
`define CROSS_BIT   9
`define MODE_HI     11
`define MODE_LO     10
`define RESET_PC    32'h0000_0000
`endif

/* File: shared/vliw_dispatch_pkg.sv */
// types shared by the dispatcher and whoever drives or watches it
// assumes the constants header is on the include path
`include "vliw_dispatch_params.svh"
package vliw_dispatch_pkg;
    typedef enum logic [1:0] {
        MODE_WORD,   // single 32-bit or 40-bit in low word
        MODE_DUAL16, // two packed halves
        MODE_QUAD8,  // four packed bytes
        MODE_PAIR64  // even/odd register pair
    } op_mode_t;

    typedef enum {ST_REQ, ST_WAIT, ST_RUN} disp_state_t;

    typedef struct packed {
        logic        en;
        logic [4:0]  idx;
        logic [31:0] data;
    } wb_port_t;

    typedef struct packed {
        logic [31:0] instr;
        op_mode_t    mode;
        logic [31:0] opnd;
        logic [31:0] opnd_hi;
    } issue_slot_t;
endpackage : vliw_dispatch_pkg

/* File: tb/vliw_dispatch_monitor.sv */
// checker on dispatcher ports: fetch pacing, stall slot, issue routing
// assumes it is bound into the dispatcher and sees only its ports
`include "vliw_dispatch_params.svh"
module vliw_dispatch_monitor (
    input wire logic                                    sys_clk,
    input wire logic                                    rst,
    input wire logic                                    fetch_req,
    input wire logic [31:0]                             fetch_addr,
    input wire logic                                    fetch_valid,
    input wire logic [`GROUP_WORDS-1:0][31:0]           fetch_data,
    input wire logic [`NUM_UNITS-1:0]                   issue_valid,
    input wire vliw_dispatch_pkg::issue_slot_t [7:0]    issue_slot,
    input wire logic                                    stall,
    input wire vliw_dispatch_pkg::wb_port_t [7:0]       wb_port
);
    logic        seen;
    logic        slot_ok;
    logic [31:0] last_addr;
    // remember the previous group request address
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            seen      <= 1'b0;
            last_addr <= 32'h0;
        end else if (fetch_req) begin
            seen      <= 1'b1;
            last_addr <= fetch_addr;
        end
    end
    // a live slot carries an instruction for its own unit and mode
    always_comb begin
        slot_ok = 1'b1;
        for (int u = 0; u < 8; u++) begin
            if (issue_valid[u] && (issue_slot[u].instr[`UNIT_HI:`UNIT_LO] != 3'(u)
                || 2'(issue_slot[u].mode) != issue_slot[u].instr[`MODE_HI:`MODE_LO]))
                slot_ok = 1'b0;
        end
    end
    sequence resume_s;
        !stall && issue_valid != 8'h00;
    endsequence
    sequence quiet_s;
        !fetch_req [*2];
    endsequence
    default clocking dcb @(posedge sys_clk); endclocking
    default disable iff (rst);
    req_pulse_a: assert property (fetch_req |=> !fetch_req)
        else $error("fetch request longer than one cycle");
    first_addr_a: assert property (fetch_req && !seen |-> fetch_addr == `RESET_PC)
        else $error("first fetch not at reset address");
    addr_step_a: assert property (fetch_req && seen |-> fetch_addr == last_addr + `GROUP_BYTES)
        else $error("fetch address did not step one group");
    fetch_hold_a: assert property (fetch_valid |=> quiet_s)
        else $error("new fetch before group dispatched");
    valid_ans_a: assert property (fetch_valid |-> ##[1:4] (issue_valid != 8'h00 || stall || fetch_req))
        else $error("fetched group produced no activity");
    stall_idle_a: assert property (stall |-> issue_valid == 8'h00)
        else $error("issue during stall cycle");
    stall_resume_a: assert property (stall |=> resume_s)
        else $error("stall not single or packet not issued after");
    slot_route_a: assert property (slot_ok)
        else $error("slot holds instruction of another unit");
endmodule : vliw_dispatch_monitor
bind vliw_packet_dispatch_crosspath vliw_dispatch_monitor mon_u (.sys_clk(sys_clk), .rst(rst),
    .fetch_req(fetch_req), .fetch_addr(fetch_addr), .fetch_valid(fetch_valid),
    .fetch_data(fetch_data), .issue_valid(issue_valid), .issue_slot(issue_slot),
    .stall(stall), .wb_port(wb_port));

/* File: tb/fetch_mem_model.sv */
// program memory model: one valid pulse with the group per request
// assumes fetch_addr stands until the next request
`include "vliw_dispatch_params.svh"
module fetch_mem_model (
    input  wire logic                           sys_clk,
    input  wire logic                           rst,
    input  wire logic                           slow,
    input  wire logic [3:0][7:0][31:0]          prog,
    input  wire logic                           fetch_req,
    input  wire logic [31:0]                    fetch_addr,
    output logic                                fetch_valid,
    output logic [`GROUP_WORDS-1:0][31:0]       fetch_data
);
    timeunit 1ns;
    timeprecision 100ps;
    logic       pend;
    logic [1:0] wait_cnt;
    // one request in flight; released data bus toggles every cycle
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            pend        <= 1'b0;
            wait_cnt    <= 2'h0;
            fetch_valid <= 1'b0;
            fetch_data  <= '1;
        end else begin
            fetch_valid <= 1'b0;
            fetch_data  <= ~fetch_data;
            if (fetch_req) begin
                pend     <= 1'b1;
                wait_cnt <= slow ? 2'h2 : 2'h0;
            end else if (pend && wait_cnt != 2'h0) begin
                wait_cnt <= wait_cnt - 2'h1;
            end else if (pend) begin
                pend        <= 1'b0;
                fetch_valid <= 1'b1;
                fetch_data  <= prog[fetch_addr[6:5]]; // whole 256-bit group
            end
        end
    end
endmodule : fetch_mem_model

/* File: tb/vliw_packet_dispatch_crosspath_bench.sv */
// self-checking bench: random programs, writebacks and fetch latency
// assumes package, dispatcher, memory model and checker compiled first
`include "vliw_dispatch_params.svh"
module vliw_packet_dispatch_crosspath_bench;
    timeunit 1ns;
    timeprecision 100ps;
    logic                                sys_clk = 1'b0;
    logic                                rst = 1'b1;
    logic                                slow = 1'b0;
    logic                                fetch_req;
    logic                                fetch_valid;
    logic                                stall;
    logic [31:0]                         fetch_addr;
    logic [31:0]                         word;
    logic [31:0]                         seed = 32'h43;
    logic [31:0]                         wseed = 32'h43;
    logic [7:0][31:0]                    fetch_data;
    logic [3:0][7:0][31:0]               prog = '0;
    logic [7:0]                          issue_valid;
    logic [7:0]                          mask;
    logic [7:0]                          exp_q[$];
    logic [7:0][31:0]                    ins;
    logic [7:0][31:0]                    exp_i[$];
    logic [7:0][31:0]                    got_i;
    vliw_dispatch_pkg::issue_slot_t [7:0] issue_slot;
    vliw_dispatch_pkg::wb_port_t [7:0]    wb_port = '0;
    int                                  failures = 0;
    int                                  check_count = 0;
    int                                  cycles = 0;
    int                                  len;

    vliw_packet_dispatch_crosspath dut_u (.sys_clk(sys_clk), .rst(rst), .fetch_req(fetch_req),
        .fetch_addr(fetch_addr), .fetch_valid(fetch_valid), .fetch_data(fetch_data),
        .issue_valid(issue_valid), .issue_slot(issue_slot), .stall(stall), .wb_port(wb_port));
    fetch_mem_model mem_u (.sys_clk(sys_clk), .rst(rst), .slow(slow), .prog(prog),
        .fetch_req(fetch_req), .fetch_addr(fetch_addr), .fetch_valid(fetch_valid),
        .fetch_data(fetch_data));

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        for (int i = 0; i < 16; i++) s = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
        return s;
    endfunction : lfsr

    task automatic cmp_mask(input logic [7:0] exp, input logic [7:0] got);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED at %0t: expected %h got %h", $time, exp, got);
        end
    endtask : cmp_mask

    task automatic cmp_instr(input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED at %0t: expected %h got %h", $time, exp, got);
        end
    endtask : cmp_instr

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : print_verdict

    always #12.5 sys_clk = ~sys_clk;
    // cut a hung run short
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 3000) begin
            failures++;
            print_verdict();
        end
    end
    // random writebacks into both files, so cross reads meet fresh writes
    always @(posedge sys_clk) begin
        for (int u = 0; u < 8; u++) begin
            wseed = lfsr(wseed);
            wb_port[u] <= '{wseed[31], wseed[8:4], wseed};
        end
    end
    // each issued packet against the oldest expected unit mask
    always @(negedge sys_clk) begin
        if (issue_valid !== 8'h00) begin
            if (exp_q.size() == 0) cmp_mask(8'h00, issue_valid);
            else cmp_mask(exp_q.pop_front(), issue_valid);
            if (exp_i.size() != 0) begin
                got_i = exp_i.pop_front();
                for (int u = 0; u < 8; u++) begin
                    if (issue_valid[u]) cmp_instr(got_i[u], issue_slot[u].instr);
                end
            end
        end
    end
    // rounds: chained spans, random chains, single-instruction packets
    initial begin
        for (int r = 0; r < 3; r++) begin
            repeat (5) @(posedge sys_clk);
            slow <= r[0];
            mask = 8'h00;
            len = 0;
            for (int w = 0; w < 32; w++) begin
                seed = lfsr(seed);
                word = seed;
                word[0] = r < 2 && (seed[0] || (r == 0 && w % 8 == 7)) && len < 7 && w != 31;
                prog[w / 8][w % 8] = word;
                mask[word[3:1]] = 1'b1;
                ins[word[3:1]] = word; // later word for a unit wins
                len++;
                if (!word[0]) begin
                    exp_q.push_back(mask);
                    exp_i.push_back(ins);
                    mask = 8'h00;
                    len = 0;
                end
            end
            rst <= 1'b0;
            while (exp_q.size() != 0) @(posedge sys_clk);
            rst <= 1'b1;
            $display("round %0d done", r);
        end
        repeat (5) @(posedge sys_clk);
        print_verdict();
    end
endmodule : vliw_packet_dispatch_crosspath_bench
